// File: hw/lla_pkg.sv
// Purpose: shared constants and types of the liquid level alarm core
// Assumes: core_clk is the divided-down internal RC oscillator
// Notes:   waveform times are given in ms and turned into oscillator cycles here; delays are given in cycles
package lla_pkg;

  // nominal oscillator rate that the printed times refer to
  localparam int OSC_HZ = 1600;

  // convert a time in ms into oscillator cycles, at least one
  function automatic int lla_cycles_ms(input int ms);
    int cyc;
    cyc = (ms * OSC_HZ) / 1000;
    return (cyc < 1) ? 1 : cyc;
  endfunction : lla_cycles_ms

  // sensor drive divider: oscillator / 32, 50 percent duty
  localparam int        DIV_W    = 5;
  localparam logic [4:0] DIV_LAST = 5'h1F;  // last cycle of the high half
  localparam int        DIV_HALF = 16;

  // qualifier: consecutive alarm samples needed
  localparam int         RUN_W    = 3;
  localparam logic [2:0] RUN_NEED = 3'h4;

  // alarm waveform, times as printed
  localparam int WAVE_PERIOD_MS = 320;
  localparam int ON_NARROW_MS   = 5;
  localparam int ON_WIDE_MS     = 160;
  localparam int WAVE_W         = 9;
  localparam int WAVE_PERIOD_CYC = lla_cycles_ms(WAVE_PERIOD_MS);   // 512
  localparam logic [9:0] ON_NARROW_CYC = 10'(lla_cycles_ms(ON_NARROW_MS)); // 8
  localparam logic [9:0] ON_WIDE_CYC   = 10'(lla_cycles_ms(ON_WIDE_MS));   // 256

  // alarm delay in oscillator cycles
  localparam int DELAY_W        = 16;
  localparam int DELAY_SHORT_CYC = 16384;
  localparam int DELAY_LONG_CYC  = 32768;

  // reset values
  localparam logic [4:0] DIV_RST   = 5'h00;
  localparam logic [2:0] RUN_RST   = 3'h0;
  localparam logic [8:0] WAVE_RST  = 9'h000;
  localparam logic [15:0] DELAY_RST = 16'h0000;

  // alarm sequencing
  typedef enum logic [1:0] {
    ST_WATCH = 2'b00,
    ST_DELAY = 2'b01,
    ST_ALARM = 2'b10
  } lla_state_t;

endpackage : lla_pkg

// File: hw/lla_sample_if.sv
// Purpose: carries sensor samples from the front end to the qualifier
// Assumes: one clock, the oscillator
// Notes:   samplePulse is one cycle wide, once per drive period
`timescale 1ns/1ps
interface lla_sample_if;
  logic samplePulse;  // take one qualification step
  logic alarmCond;    // sampled alarm condition, valid with samplePulse
  logic indication;   // qualified alarm indication

  modport front (output samplePulse, output alarmCond, input indication);
  modport qual  (input samplePulse, input alarmCond, output indication);
endinterface : lla_sample_if

// File: hw/lla_qualifier.sv
// Purpose: counts consecutive alarm samples before raising an indication
// Assumes: samples arrive one per sensor drive period
// Notes:   saturates at the needed count so the indication holds
`timescale 1ns/1ps
module lla_qualifier (
  input  wire logic core_clk,
  input  wire logic nrst,
  lla_sample_if.qual smp
);

  logic [2:0] runLen;
  logic [2:0] next_runLen;

  // RULE_10: consecutive run
  assign next_runLen = !smp.alarmCond      ? lla_pkg::RUN_RST :
                       (runLen == lla_pkg::RUN_NEED) ? runLen :
                       3'(runLen + 3'h1);

  // count only on a sample step; a clean sample starts over
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      runLen         <= lla_pkg::RUN_RST;
      smp.indication <= 1'b0;
    end else if (smp.samplePulse) begin
      runLen         <= next_runLen;
      smp.indication <= (next_runLen == lla_pkg::RUN_NEED);
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  property p_qual_clear;
    smp.samplePulse && !smp.alarmCond |=> !smp.indication;
  endproperty
  a_qual_clear: assert property (p_qual_clear) // RULE_10
    else $error("indication survived a clean sample");

  property p_qual_fourth;
    smp.samplePulse && smp.alarmCond && runLen == 3'h3 |=> smp.indication;
  endproperty
  a_qual_fourth: assert property (p_qual_fourth) // RULE_10
    else $error("no indication after fourth alarm sample");

  property p_qual_early;
    smp.samplePulse && runLen < 3'h3 |=> !smp.indication;
  endproperty
  a_qual_early: assert property (p_qual_early) // RULE_10
    else $error("indication before four samples");

endmodule : lla_qualifier

// File: hw/lla_alarm.sv
// Purpose: digital core of a liquid level alarm
// Assumes: core_clk is the internal oscillator, nrst the undervoltage reset
// Notes:   comparator and program pins are asynchronous and are synchronised
//
// How it works
// RULE_01: sensor drive is oscillator divided by 32
// RULE_02: comparator ignored while drive is low
// RULE_03: comparator state keeps hysteresis, both polarities
// RULE_04: select low: above threshold alarms, 1:64
// RULE_05: select high: below threshold alarms, 50 percent
// RULE_06: alarm only after selected delay elapses
// RULE_07: condition lost during delay abandons it
// RULE_08: alarm latched until internal reset
// RULE_09: undervoltage reset clears latch, delay, qualifier
// RULE_10: four consecutive alarm samples give indication
// RULE_11: alarm wave period is 512 cycles
// RULE_12: delay 16384 or 32768 cycles by select
// RULE_13: one sample per period, end of high
`timescale 1ns/1ps
module lla_alarm #(
  parameter int DELAY_SHORT = lla_pkg::DELAY_SHORT_CYC,
  parameter int DELAY_LONG  = lla_pkg::DELAY_LONG_CYC
) (
  input  wire logic core_clk,
  input  wire logic nrst,
  input  wire logic upperSenseHit,  // input above upper_sense_threshold
  input  wire logic lowerSenseHit,  // input above lower_sense_threshold
  input  wire logic delaySel,       // high selects the longer delay
  input  wire logic polaritySel,    // sensor polarity and duty select
  output logic      sensorDrive,    // squarewave to the sensor
  output logic      alarmDrive      // high turns the output sink on
);

  // two-stage synchronisers for the four pins
  logic [3:0] pinMeta;
  logic [3:0] pinSync;

  logic       upperS;
  logic       lowerS;
  logic       delayS;
  logic       polarityS;

  logic [4:0] divCnt;
  logic       sensHigh;
  logic       driveHigh;
  logic       sampleNow;
  logic [1:0] driveDly;
  logic       senseWin;

  lla_pkg::lla_state_t state;
  lla_pkg::lla_state_t next_state;
  logic [15:0]         delayCnt;
  logic [15:0]         next_delayCnt;
  logic [15:0]         delayLast;
  logic                delayDone;

  logic [8:0] waveCnt;
  logic [9:0] onLen;
  logic       next_alarmDrive;

  lla_sample_if smp ();

  // the first stage feeds only the second stage
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      pinMeta <= 4'h0;
      pinSync <= 4'h0;
    end else begin
      pinMeta <= {polaritySel, delaySel, lowerSenseHit, upperSenseHit};
      pinSync <= pinMeta;
    end
  end

  assign upperS    = pinSync[0];
  assign lowerS    = pinSync[1];
  assign delayS    = pinSync[2];
  assign polarityS = pinSync[3];

  // RULE_01: divide by 32
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      divCnt <= lla_pkg::DIV_RST;
    end else begin
      divCnt <= 5'(divCnt + 5'h01);
    end
  end

  // top divider bit is a flop, so the drive is glitch free
  assign driveHigh   = divCnt[4];
  assign sensorDrive = driveHigh;

  // the pin synchronisers lag two cycles, so the first two high cycles still
  // carry samples from the low half; the window opens once those have passed
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      driveDly <= 2'h0;
    end else begin
      driveDly <= {driveDly[0], driveHigh};
    end
  end

  // RULE_02: listen only to high-half samples
  assign senseWin = driveHigh && driveDly[1];

  // RULE_03: schmitt hysteresis
  // RULE_02: frozen while drive low
  // crossing the upper level sets the state, only dropping under the lower
  // level clears it; between the two it holds
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      sensHigh <= 1'b0;
    end else if (senseWin) begin
      if (upperS) begin
        sensHigh <= 1'b1;
      end else if (!lowerS) begin
        sensHigh <= 1'b0;
      end
    end
  end

  // RULE_13: sample at end of high half
  assign sampleNow = (divCnt == lla_pkg::DIV_LAST);

  // RULE_04: low select, above alarms
  // RULE_05: high select, below alarms
  assign smp.samplePulse = sampleNow;
  assign smp.alarmCond   = polarityS ? !sensHigh : sensHigh;

  // RULE_10: four-sample qualifier
  lla_qualifier u_qual (
    .core_clk (core_clk),
    .nrst     (nrst),
    .smp      (smp)
  );

  // RULE_12: delay length by select
  assign delayLast = delayS ? 16'(DELAY_LONG - 1) : 16'(DELAY_SHORT - 1);
  assign delayDone = (delayCnt == delayLast);

  // RULE_06: wait out the delay
  // RULE_07: lost condition abandons delay
  // RULE_08: alarm state never left
  always_comb begin
    next_state    = state;
    next_delayCnt = lla_pkg::DELAY_RST;
    unique case (state)
      lla_pkg::ST_WATCH: begin
        if (smp.indication) begin
          next_state = lla_pkg::ST_DELAY;
        end
      end
      lla_pkg::ST_DELAY: begin
        if (!smp.indication) begin
          next_state = lla_pkg::ST_WATCH;
        end else if (delayDone) begin
          next_state = lla_pkg::ST_ALARM;
        end else begin
          next_delayCnt = 16'(delayCnt + 16'h0001);
        end
      end
      lla_pkg::ST_ALARM: begin
        next_state = lla_pkg::ST_ALARM;
      end
      default: begin
        next_state = lla_pkg::ST_WATCH;  // unused code recovers
      end
    endcase
  end

  // RULE_09: reset clears all state
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state    <= lla_pkg::ST_WATCH;
      delayCnt <= lla_pkg::DELAY_RST;
    end else begin
      state    <= next_state;
      delayCnt <= next_delayCnt;
    end
  end

  // RULE_11: 512-cycle period
  // the 9-bit counter wraps by itself, so no compare is needed
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      waveCnt <= lla_pkg::WAVE_RST;
    end else if (state == lla_pkg::ST_ALARM) begin
      waveCnt <= 9'(waveCnt + 9'h001);
    end
  end

  // RULE_04: 8-cycle on-time
  // RULE_05: 256-cycle on-time
  // duty follows the pin live; a change mid-period bends one period only
  assign onLen           = polarityS ? lla_pkg::ON_WIDE_CYC : lla_pkg::ON_NARROW_CYC;
  assign next_alarmDrive = (state == lla_pkg::ST_ALARM) && ({1'b0, waveCnt} < onLen);

  // registered output, so the driver sees no decode glitches
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      alarmDrive <= 1'b0;
    end else begin
      alarmDrive <= next_alarmDrive;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst);

  sequence s_drive_high;
    ##16 $fell(sensorDrive);
  endsequence

  sequence s_drive_low;
    ##16 $rose(sensorDrive);
  endsequence

  property p_drive_div;
    $rose(sensorDrive) |-> s_drive_high ##0 s_drive_low;
  endproperty
  a_drive_div: assert property (p_drive_div) // RULE_01
    else $error("sensor drive is not a 32-cycle square");

  property p_sample_high;
    smp.samplePulse |-> sensorDrive ##1 !sensorDrive;
  endproperty
  a_sample_high: assert property (p_sample_high) // RULE_13
    else $error("sample not at end of high half");

  property p_hold_low;
    !sensorDrive |=> $stable(sensHigh);
  endproperty
  a_hold_low: assert property (p_hold_low) // RULE_02
    else $error("comparator state moved while drive low");

  // stale low-half samples must not reach the hysteresis state
  property p_stale;
    $rose(sensorDrive) |=> $stable(sensHigh) ##1 $stable(sensHigh);
  endproperty
  a_stale: assert property (p_stale) // RULE_02
    else $error("comparator moved on a low-half sample");

  property p_hyst;
    sensorDrive && lowerS && !upperS |=> $stable(sensHigh);
  endproperty
  a_hyst: assert property (p_hyst) // RULE_03
    else $error("hysteresis band not held");

  property p_pol;
    smp.samplePulse |-> smp.alarmCond == (sensHigh ^ polarityS);
  endproperty
  a_pol: assert property (p_pol) // RULE_05
    else $error("alarm condition polarity wrong");

  property p_narrow;
    $rose(alarmDrive) && !polarityS |-> alarmDrive[*8] ##1 !alarmDrive;
  endproperty
  a_narrow: assert property (p_narrow) // RULE_04
    else $error("narrow on-time is not 8 cycles");

  property p_wide;
    $rose(alarmDrive) && polarityS |-> ##256 $fell(alarmDrive);
  endproperty
  a_wide: assert property (p_wide) // RULE_05
    else $error("wide on-time is not 256 cycles");

  property p_period;
    $rose(alarmDrive) |-> ##[512:512] $rose(alarmDrive);
  endproperty
  a_period: assert property (p_period) // RULE_11
    else $error("alarm period is not 512 cycles");

  property p_delay_end;
    state == lla_pkg::ST_DELAY && smp.indication && delayDone
      |=> state == lla_pkg::ST_ALARM;
  endproperty
  a_delay_end: assert property (p_delay_end) // RULE_12
    else $error("delay end did not raise the alarm");

  property p_no_early;
    state == lla_pkg::ST_DELAY && !delayDone |=> state != lla_pkg::ST_ALARM;
  endproperty
  a_no_early: assert property (p_no_early) // RULE_06
    else $error("alarm before the delay ran out");

  property p_abandon;
    state == lla_pkg::ST_DELAY && !smp.indication
      |=> state == lla_pkg::ST_WATCH && delayCnt == 16'h0000;
  endproperty
  a_abandon: assert property (p_abandon) // RULE_07
    else $error("delay not abandoned");

  property p_latch;
    state == lla_pkg::ST_ALARM |=> state == lla_pkg::ST_ALARM;
  endproperty
  a_latch: assert property (p_latch) // RULE_08
    else $error("alarm latch released");

endmodule : lla_alarm

// File: testbench/lla_sensor_model.sv
// Purpose: sensor tip and comparators as seen from the alarm core
// Assumes: liquidLevel 0 below lower, 1 between, 2 above upper threshold
// Notes:   with the drive low the tip sees no signal, so both hits drop
`timescale 1ns/1ps
module lla_sensor_model (
  input  wire logic       sensorDrive,
  input  wire logic [1:0] liquidLevel,
  output logic            upperSenseHit,
  output logic            lowerSenseHit
);
  // drive low silences
  // hits only exist in the high half; a core that listens in the low half sees 0
  assign upperSenseHit = sensorDrive & (liquidLevel == 2'h2);
  assign lowerSenseHit = sensorDrive & (liquidLevel != 2'h0);
endmodule : lla_sensor_model

// File: testbench/liquid_level_alarm_logic_bench.sv
// Purpose: self-checking bench of the liquid level alarm core
// Assumes: delays shortened by parameter to keep the run short
// Notes:   inputs change on the falling edge, counts taken there too
`timescale 1ns/1ps
module liquid_level_alarm_logic_bench;
  localparam int DS = 20;
  localparam int DL = 40;
  logic       coreClk;
  logic       nrst;
  logic       delaySel;
  logic       polaritySel;
  logic [1:0] liquidLevel;
  wire        upperSenseHit;
  wire        lowerSenseHit;
  wire        sensorDrive;
  wire        alarmDrive;
  int         errors;
  int         checks;
  int         n;

  lla_alarm #(.DELAY_SHORT(DS), .DELAY_LONG(DL)) u_lla_alarm (
    .core_clk(coreClk), .nrst(nrst), .upperSenseHit(upperSenseHit),
    .lowerSenseHit(lowerSenseHit), .delaySel(delaySel), .polaritySel(polaritySel),
    .sensorDrive(sensorDrive), .alarmDrive(alarmDrive));

  lla_sensor_model u_lla_sensor_model (
    .sensorDrive(sensorDrive), .liquidLevel(liquidLevel),
    .upperSenseHit(upperSenseHit), .lowerSenseHit(lowerSenseHit));

  // 200 MHz clock
  initial begin
    coreClk = 1'b0;
    forever #2.5 coreClk = ~coreClk;
  end

  task end_of_test;
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : end_of_test

  task chk(input logic [15:0] seen, input logic [15:0] exp, input string msg);
    checks++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %0t %s seen %0h expected %0h", $time, msg, seen, exp);
    end
  endtask : chk

  // bounded wait for a level on one output; a hang ends the run
  task wait_for(input logic alarmSide, input logic v, input int lim, output int cnt);
    cnt = 0;
    while (((alarmSide ? alarmDrive : sensorDrive) !== v) && cnt < lim) begin
      @(negedge coreClk);
      cnt++;
    end
    if (cnt >= lim) begin
      errors++;
      $display("BAD %0t wait ran out", $time);
      end_of_test();
    end
  endtask : wait_for

  // alarm must stay off for the whole span
  task quiet(input int lim, input string msg);
    logic seenOn;
    seenOn = 1'b0;
    repeat (lim) begin
      @(negedge coreClk);
      if (alarmDrive !== 1'b0) seenOn = 1'b1;
    end
    chk(16'(seenOn), 16'h0000, msg);
  endtask : quiet

  task do_reset(input logic pol, input logic dsel, input logic [1:0] lvl);
    nrst        = 1'b0;
    polaritySel = pol;
    delaySel    = dsel;
    liquidLevel = lvl;
    @(negedge coreClk);
    chk(16'({sensorDrive, alarmDrive}), 16'h0000, "outputs in reset");
    repeat (11) @(negedge coreClk);
    nrst = 1'b1;
  endtask : do_reset

  task t_divider;
    do_reset(1'b0, 1'b0, 2'h0);
    wait_for(1'b0, 1'b1, 40, n);
    chk(16'(n), 16'h0010, "first drive rise");
    wait_for(1'b0, 1'b0, 40, n);
    chk(16'(n), 16'h0010, "drive high half");
    wait_for(1'b0, 1'b1, 40, n);
    chk(16'(n), 16'h0010, "drive low half");
    $display("divider test done");
  endtask : t_divider

  // full alarm: delay, waveform, latch, then reset clears it
  task t_alarm(input logic pol, input logic dsel, input logic [1:0] lvl);
    int dly;
    int onCyc;
    dly   = dsel ? DL : DS;
    onCyc = pol ? 256 : 8;
    do_reset(pol, dsel, lvl);
    wait_for(1'b1, 1'b1, 2000, n);
    chk(16'(n >= 120 + dly && n <= 145 + dly), 16'h0001, "alarm onset");
    wait_for(1'b1, 1'b0, 600, n);
    chk(16'(n), 16'(onCyc), "on time");
    wait_for(1'b1, 1'b1, 600, n);
    chk(16'(n), 16'(512 - onCyc), "off time");
    liquidLevel = pol ? 2'h2 : 2'h0;
    wait_for(1'b1, 1'b0, 600, n);
    wait_for(1'b1, 1'b1, 600, n);
    chk(16'(n), 16'(512 - onCyc), "latched wave");
    do_reset(pol, dsel, liquidLevel);
    quiet(700, "alarm after reset");
    $display("alarm test done pol %0b dsel %0b", pol, dsel);
  endtask : t_alarm

  // three samples only: no indication
  task t_three;
    do_reset(1'b0, 1'b0, 2'h2);
    repeat (100) @(negedge coreClk);
    liquidLevel = 2'h0;
    quiet(500, "three samples alarmed");
    $display("qualifier test done");
  endtask : t_three

  // indication lost inside the long delay
  task t_abandon;
    do_reset(1'b0, 1'b1, 2'h2);
    repeat (136) @(negedge coreClk);
    liquidLevel = 2'h0;
    quiet(600, "abandoned delay alarmed");
    $display("abandon test done");
  endtask : t_abandon

  // between thresholds after a high crossing keeps the high state
  task t_hyst;
    do_reset(1'b1, 1'b0, 2'h2);
    repeat (100) @(negedge coreClk);
    liquidLevel = 2'h1;
    quiet(600, "hysteresis lost");
    liquidLevel = 2'h0;
    wait_for(1'b1, 1'b1, 1000, n);
    chk(16'(n <= 200 + DS), 16'h0001, "inverted polarity alarm");
    $display("hysteresis test done");
  endtask : t_hyst

  initial begin
    errors      = 0;
    checks      = 0;
    nrst        = 1'b0;
    delaySel    = 1'b0;
    polaritySel = 1'b0;
    liquidLevel = 2'h0;
    t_divider();
    t_alarm(1'b0, 1'b0, 2'h2);
    t_alarm(1'b1, 1'b1, 2'h0);
    t_three();
    t_abandon();
    t_hyst();
    end_of_test();
  end
endmodule : liquid_level_alarm_logic_bench
